//--- core/aop_pkg.sv
// Function
// - Output word is offset binary when format select is high, else two's complement.
// - Overrange flag is high when the sample lay outside the convertible range.
// - A forwarded data clock is a delayed copy of the encode clock.
// - Data word and overrange flag change just after the forwarded clock falls.
package aop_pkg;
    localparam int DATA_W         = 14;
    localparam int WORD_W         = 15;
    localparam int OVR_BIT        = 14;
    localparam int MSB_BIT        = 13;
    localparam int FIFO_DEPTH     = 16;
    localparam int MAX_RATE_MSPS  = 80;
    localparam int MIN_RATE_MSPS  = 1;
    localparam int HALF_PERIOD_NS = 6;
    localparam int CORE_CLK_MHZ   = 100;
    localparam int HALF_PERIOD_CYC = (HALF_PERIOD_NS * CORE_CLK_MHZ + 999) / 1000;
    localparam logic [DATA_W-1:0] DATA_RST = 14'h0000;
endpackage : aop_pkg

//--- core/aop_fifo.sv
`timescale 1ns/10ps
module aop_fifo #(
    parameter int WIDTH = 15,
    parameter int DEPTH = 16
) (
    input  wire logic             i_clk,      // Core clock.
    input  wire logic             i_rstn,     // Asynchronous reset, active low.
    input  wire logic             i_wr_valid, // Write word offered.
    output logic                  o_wr_ready, // Room for a word.
    input  wire logic [WIDTH-1:0] i_wr_data,  // Write word.
    output logic                  o_rd_valid, // Word available.
    input  wire logic             i_rd_ready, // Reader takes the word.
    output logic      [WIDTH-1:0] o_rd_data   // Head word.
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0]    wr_ptr_r;
    logic [PW-1:0]    rd_ptr_r;
    logic [PW:0]      count_r;
    wire              push_w = i_wr_valid & o_wr_ready;
    wire              pop_w  = o_rd_valid & i_rd_ready;

    // Room is offered until all DEPTH slots hold a word.
    assign o_wr_ready = (count_r < (PW+1)'(DEPTH));
    assign o_rd_valid = (count_r != '0);
    assign o_rd_data  = mem_r[rd_ptr_r];

    always_ff @(posedge i_clk) begin
        if (push_w) begin
            mem_r[wr_ptr_r] <= i_wr_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            wr_ptr_r <= push_w ? PW'(wr_ptr_r + 1'b1) : wr_ptr_r;
            rd_ptr_r <= pop_w ? PW'(rd_ptr_r + 1'b1) : rd_ptr_r;
            count_r  <= (PW+1)'(count_r + push_w - pop_w);
        end
    end

    a_fifo_bound: assert property (@(posedge i_clk) disable iff (!i_rstn)
        count_r <= (PW+1)'(DEPTH)) else $error("fifo count above depth");
    a_fifo_full_stop: assert property (@(posedge i_clk) disable iff (!i_rstn)
        count_r == (PW+1)'(DEPTH) |-> !o_wr_ready) else $error("fifo offers room while full");
    a_fifo_head_hold: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_rd_valid && !i_rd_ready |=> $stable(o_rd_data)) else $error("fifo head changed while waiting");
endmodule : aop_fifo

//--- core/aop_port.sv
`timescale 1ns/10ps
module aop_port
    import aop_pkg::*;
(
    input  wire logic              i_core_clk,             // Core clock, 100 MHz.
    input  wire logic              i_rstn,                 // Asynchronous reset, active low.
    input  wire logic              i_sample_valid,         // Conversion result offered.
    output logic                   o_sample_ready,         // Result accepted when high.
    input  wire logic [DATA_W-1:0] i_sample_code,          // Result, two's complement.
    input  wire logic              i_sample_overrange,     // Result lay outside the range.
    input  wire logic              i_encode_clock_in,      // Encode clock, link domain.
    input  wire logic              i_output_format_select, // High selects offset binary.
    output logic      [DATA_W-1:0] o_data_word,            // Parallel output word.
    output logic                   o_overrange_flag,       // Overrange of the same sample.
    output logic                   o_forwarded_data_clock  // Delayed copy of the encode clock.
);
    // ------------------------------------------------------------------
    // Core side: buffer and launch of words toward the link.
    // ------------------------------------------------------------------
    logic              fifo_valid_w;
    logic [WORD_W-1:0] fifo_data_w;
    logic [WORD_W-1:0] xfer_data_r;
    logic              req_r;
    logic              ack_s1_r;
    logic              ack_s2_r;
    logic              ack_r;
    // A toggle handshake carries each word across: the core launches by toggling the
    // request and may not launch again until the synchronised acknowledge matches it.
    wire               busy_w   = req_r ^ ack_s2_r;
    wire               launch_w = fifo_valid_w & ~busy_w;

    aop_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clk      (i_core_clk),
        .i_rstn     (i_rstn),
        .i_wr_valid (i_sample_valid),
        .o_wr_ready (o_sample_ready),
        .i_wr_data  ({i_sample_overrange, i_sample_code}),
        .o_rd_valid (fifo_valid_w),
        .i_rd_ready (~busy_w),
        .o_rd_data  (fifo_data_w)
    );

    // The acknowledge toggle comes from the link domain and passes two flip-flops here.
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ack_s1_r <= 1'b0;
            ack_s2_r <= 1'b0;
        end else begin
            ack_s1_r <= ack_r;
            ack_s2_r <= ack_s1_r;
        end
    end

    // The word stays in the transfer register from launch until its acknowledge returns,
    // so the link side may read it at any edge while the request is pending.
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            xfer_data_r <= '0;
            req_r       <= 1'b0;
        end else if (launch_w) begin
            xfer_data_r <= fifo_data_w;
            req_r       <= ~req_r;
        end
    end

    // ------------------------------------------------------------------
    // Link side: words leave on the falling edge of the encode clock.
    // ------------------------------------------------------------------
    logic              req_s1_r;
    logic              req_s2_r;
    logic              fmt_s1_r;
    logic              fmt_s2_r;
    logic [DATA_W-1:0] data_r;
    logic              ovr_r;
    wire               load_w = req_s2_r ^ ack_r;
    wire  [DATA_W-1:0] code_w = xfer_data_r[DATA_W-1:0];
    // Offset binary is two's complement with the sign bit inverted.
    wire  [DATA_W-1:0] fmt_code_w = fmt_s2_r ? {~code_w[MSB_BIT], code_w[MSB_BIT-1:0]} : code_w;

    // Request toggle and format select each pass two flip-flops on the falling encode edge.
    always_ff @(negedge i_encode_clock_in or negedge i_rstn) begin
        if (!i_rstn) begin
            req_s1_r <= 1'b0;
            req_s2_r <= 1'b0;
            fmt_s1_r <= 1'b0;
            fmt_s2_r <= 1'b0;
        end else begin
            req_s1_r <= req_r;
            req_s2_r <= req_s1_r;
            fmt_s1_r <= i_output_format_select;
            fmt_s2_r <= fmt_s1_r;
        end
    end

    // Word and flag load together on the falling edge, so both settle before the next rise.
    always_ff @(negedge i_encode_clock_in or negedge i_rstn) begin
        if (!i_rstn) begin
            ack_r  <= 1'b0;
            data_r <= DATA_RST;
            ovr_r  <= 1'b0;
        end else if (load_w) begin
            ack_r  <= ~ack_r;
            data_r <= fmt_code_w;
            ovr_r  <= xfer_data_r[OVR_BIT];
        end
    end

    assign o_data_word      = data_r;
    assign o_overrange_flag = ovr_r;
    // The pad buffer gives the delay; the capturing logic times off this copy.
    assign o_forwarded_data_clock = i_encode_clock_in;

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    a_format_select: assert property (@(negedge i_encode_clock_in) disable iff (!i_rstn)
        load_w |=> o_data_word[MSB_BIT] == ($past(code_w[MSB_BIT]) ^ $past(fmt_s2_r)))
        else $error("output format does not follow the select");
    a_format_low: assert property (@(negedge i_encode_clock_in) disable iff (!i_rstn)
        load_w && !fmt_s2_r |=> o_data_word == $past(code_w))
        else $error("two's complement word altered");
    a_overrange_pair: assert property (@(negedge i_encode_clock_in) disable iff (!i_rstn)
        load_w |=> o_overrange_flag == $past(xfer_data_r[OVR_BIT]))
        else $error("overrange flag not paired with its word");
    a_change_on_fall: assert property (@(negedge i_encode_clock_in) disable iff (!i_rstn)
        !$stable(o_data_word) || !$stable(o_overrange_flag) |-> $past(load_w))
        else $error("output changed without a loaded word");
    a_clock_copy: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        $rose(i_encode_clock_in) |-> o_forwarded_data_clock)
        else $error("forwarded clock does not follow encode clock");
    a_xfer_stable: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        busy_w && $past(busy_w) |-> $stable(xfer_data_r))
        else $error("word changed during link transfer");
    a_launch_bound: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        launch_w |=> busy_w [*1] ##1 1'b1)
        else $error("launch did not start a transfer");

    c_word_out:  cover property (@(negedge i_encode_clock_in) disable iff (!i_rstn) load_w);
    c_offset:    cover property (@(negedge i_encode_clock_in) disable iff (!i_rstn) load_w && fmt_s2_r);
    c_overrange: cover property (@(negedge i_encode_clock_in) disable iff (!i_rstn) load_w && xfer_data_r[OVR_BIT]);
    c_full:      cover property (@(posedge i_core_clk) disable iff (!i_rstn) !o_sample_ready);
    c_fmt_flip:  cover property (@(negedge i_encode_clock_in) disable iff (!i_rstn) $changed(fmt_s2_r));

    // ------------------------------------------------------------------
    // Sequencing checks on the link side.
    // ------------------------------------------------------------------
    a_offset_word: assert property (@(negedge i_encode_clock_in) disable iff (!i_rstn)
        load_w && fmt_s2_r |=> o_data_word == ($past(code_w) ^ (DATA_W'(1) << MSB_BIT)))
        else $error("offset binary word does not match its code");
    a_hold_idle: assert property (@(negedge i_encode_clock_in) disable iff (!i_rstn)
        !load_w |=> $stable(o_data_word) && $stable(o_overrange_flag))
        else $error("output moved without a load");
    a_load_gap: assert property (@(negedge i_encode_clock_in) disable iff (!i_rstn)
        load_w |=> !load_w [*3])
        else $error("second load before the handshake closed");
    a_ack_toggle: assert property (@(negedge i_encode_clock_in) disable iff (!i_rstn)
        load_w |=> ack_r != $past(ack_r))
        else $error("load did not answer the request");
    a_reset_word: assert property (@(negedge i_encode_clock_in)
        $rose(i_rstn) |-> o_data_word == DATA_RST && !o_overrange_flag)
        else $error("output not at rest after reset");

    // ------------------------------------------------------------------
    // Handshake checks on the core side.
    // ------------------------------------------------------------------
    a_busy_bound: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        launch_w |-> ##[2:12] !busy_w)
        else $error("link transfer did not close in time");
    a_req_hold: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        busy_w && $past(busy_w) |-> $stable(req_r))
        else $error("request toggled during a transfer");
    a_launch_word: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        launch_w |=> xfer_data_r == $past(fifo_data_w))
        else $error("launched word differs from the fifo head");
    a_ready_reset: assert property (@(posedge i_core_clk)
        $rose(i_rstn) |-> o_sample_ready)
        else $error("no room offered after reset");
endmodule : aop_port

//--- test/aop_capture.sv
`timescale 1ns/10ps
module aop_capture
    import aop_pkg::*;
(
    input  wire logic              i_fwd_clk, // Forwarded data clock.
    input  wire logic              i_rstn,    // Reset, active low.
    input  wire logic [WORD_W-1:0] i_word     // Flag and data word.
);
    logic [WORD_W-1:0] words[$];
    logic [WORD_W-1:0] last_r = '0;
    // A held word repeats on every edge, so only a new value is kept.
    always @(posedge i_fwd_clk) begin
        if (i_rstn === 1'b1 && i_word !== last_r) begin
            words.push_back(i_word);
            last_r = i_word;
        end
    end
endmodule : aop_capture

//--- test/tb_adc_encode_and_output_port.sv
`timescale 1ns/10ps
module tb_adc_encode_and_output_port;
    import aop_pkg::*;
    logic              i_core_clk = 0, i_rstn = 0, encode_clock_in = 0, vld = 0, ovr = 0, fmt = 0;
    logic [DATA_W-1:0] code = '0;
    logic [DATA_W-1:0] dw;
    logic              of, fwd, rdy;
    logic [WORD_W-1:0] expq[$];
    logic [WORD_W-1:0] last = '0;
    int                fails = 0, cmp_count = 0, seed = 32'h0fac, n;
    int                acc = 0, first_full = -1;
    aop_port dut (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_sample_valid(vld), .o_sample_ready(rdy),
        .i_sample_code(code), .i_sample_overrange(ovr), .i_encode_clock_in(encode_clock_in),
        .i_output_format_select(fmt), .o_data_word(dw), .o_overrange_flag(of), .o_forwarded_data_clock(fwd));
    aop_capture cap (.i_fwd_clk(fwd), .i_rstn(i_rstn), .i_word({of, dw}));
    initial forever #5 i_core_clk = ~i_core_clk;
    // A 12.5 ns encode period is 80 Msps with equal 6.25 ns halves.
    localparam real ENC_HALF_NS = 6.25;
    initial begin
        #1.3;
        forever #(ENC_HALF_NS) encode_clock_in = ~encode_clock_in;
    end
    function automatic logic [WORD_W-1:0] expect_word(logic [DATA_W-1:0] c, logic o, logic f);
        return {o, f ? {~c[MSB_BIT], c[MSB_BIT-1:0]} : c};
    endfunction : expect_word
    task automatic check(string what, logic [WORD_W-1:0] seen, logic [WORD_W-1:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic give_verdict();
        $display("Compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict
    task automatic send(logic [DATA_W-1:0] c, logic o);
        logic [WORD_W-1:0] e;
        vld = 1'b1;
        code = c;
        ovr = o;
        n = 0;
        while (rdy !== 1'b1 && n < 500) begin
            if (first_full < 0) first_full = acc;
            @(posedge i_core_clk);
            #1;
            n++;
        end
        @(posedge i_core_clk);
        #1;
        acc++;
        e = expect_word(c, o, fmt);
        if (e !== last) begin
            expq.push_back(e);
            last = e;
        end
    endtask : send
    always @(dw or of) if (i_rstn === 1'b1) check("update edge", {14'h0000, fwd}, 15'h0000);
    always @(posedge i_core_clk) check("fwd clock", {14'h0000, fwd}, {14'h0000, encode_clock_in});
    // ----------------------------------------
    // Both formats, corner codes, random burst.
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge i_core_clk);
        #1;
        check("reset word", {of, dw}, {1'b0, DATA_RST});
        check("reset ready", {14'h0000, rdy}, 15'h0001);
        i_rstn = 1'b1;
        for (int f = 0; f < 2; f++) begin
            fmt = f[0];
            repeat (10) @(posedge i_core_clk);
            #1;
            send(14'h2000, 1'b1);
            send(14'h1fff, 1'b1);
            send(14'h0000, 1'b0);
            send(14'h3fff, 1'b0);
            repeat (60) send(DATA_W'($random(seed)), 1'($random(seed)));
            vld = 1'b0;
            n = 0;
            while (cap.words.size() < expq.size() && n < 3000) begin
                @(posedge i_core_clk);
                n++;
            end
        end
        check("fill depth", {14'h0000, first_full >= FIFO_DEPTH}, 15'h0001);
        check("word count", 15'(cap.words.size()), 15'(expq.size()));
        foreach (expq[i]) check("sample word", cap.words[i], expq[i]);
        give_verdict();
    end
    initial begin
        #200000;
        fails++;
        give_verdict();
    end
endmodule : tb_adc_encode_and_output_port
